/* src/stpc_ctrl.sv */
/*
 * Supply trigger and protection controller: alarm latches with restart
 * interlock, abort / initiate / trigger sequencing, calibration session,
 * configuration switches and identification string, all behind AHB-Lite.
 * Assumes one clock, fault inputs synchronous to hclk, single word transfers.
 */
// The implementer's own choices: the AHB-Lite register port and the address map.
module stpc_ctrl
   import stpc_pkg::*;
#(
   parameter logic [31:0]    CAL_PASSWORD = 32'h0000_1234,
   parameter logic [POT_W-1:0] POT_DEFAULT = 8'h80
) (
   // Clock, reset, enable
   input  wire logic                      hclk,
   input  wire logic                      hresetn,
   input  wire logic                      ce,
   // AHB-Lite slave
   input  wire logic                      hsel,
   input  wire logic [11:0]               haddr,
   input  wire logic [1:0]                htrans,
   input  wire logic                      hwrite,
   input  wire logic [2:0]                hsize,
   input  wire logic                      hready,
   input  wire logic [31:0]               hwdata,
   output logic      [31:0]               hrdata,
   output logic                           hreadyout,
   output logic                           hresp,
   // Fault detectors
   input  wire logic [NUM_ALARMS-1:0]     fault_in,
   // Supply side
   output logic                           output_run,
   output logic                           alarm_state,
   output logic      [31:0]               applied_voltage_level,
   output logic      [31:0]               applied_current_level,
   output logic                           waiting_for_trigger_flag,
   output logic                           sense_location_select,
   output logic                           front_panel_control_enable,
   output logic                           external_input_control_enable,
   output logic      [NUM_POTS*POT_W-1:0] trim_pot_setting
);

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   stpc_trg_t              trg_reg;
   logic [NUM_ALARMS-1:0]  latch_reg;
   logic [3:0]             cfg_reg;
   logic [31:0]            pend_v_reg;
   logic [31:0]            pend_c_reg;
   logic [31:0]            imm_v_reg;
   logic [31:0]            imm_c_reg;
   logic [31:0]            vscale_reg;
   logic [31:0]            cscale_reg;
   logic [31:0]            inp_fs_reg;
   logic [POT_W-1:0]       pot_reg [0:NUM_POTS-1];
   logic [7:0]             id_mem  [0:ID_CHARS-1];
   logic                   cal_open_reg;
   logic                   cal_reject_reg;
   logic                   refuse_reg;
   logic                   run_reg;
   logic                   opc_clear_reg;

   // ----------------------------------------------------------------
   // Bus phase tracking
   // ----------------------------------------------------------------
   logic                   wr_pend_reg;
   logic                   rd_pend_reg;
   logic [11:0]            addr_reg;
   logic [31:0]            rdata_next;
   logic                   addr_phase;

   assign addr_phase = hsel & htrans[1] & hready;

   // Capture address phase; reads take one wait state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg    <= 12'h000;
         hreadyout   <= 1'b1;
         hrdata      <= WORD_ZERO;
         hresp       <= 1'b0;
      end else if (ce) begin
         hresp <= 1'b0;
         if (rd_pend_reg) begin
            hrdata      <= rdata_next;
            hreadyout   <= 1'b1;
            rd_pend_reg <= 1'b0;
         end else if (addr_phase) begin
            addr_reg    <= haddr;
            wr_pend_reg <= hwrite;
            rd_pend_reg <= ~hwrite;
            hreadyout   <= hwrite;
         end else begin
            wr_pend_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   logic        wr_cmd;
   logic [31:0] cmd;
   logic        c_clear, c_abort, c_trigger_fire_cmd, c_init, c_cstop, c_cdef, c_restart, c_stop;
   logic        wr_pot_any;
   logic        wr_id;
   logic [11:0] id_ofs;
   logic [11:0] pot_ofs;

   assign wr_cmd    = wr_pend_reg & (addr_reg == OFS_CMD);
   assign cmd       = wr_cmd ? hwdata : WORD_ZERO;
   assign c_clear   = cmd[CMD_PROT_CLEAR];
   assign c_abort   = cmd[CMD_ABORT] | cmd[CMD_RECALL_RST];
   assign c_trigger_fire_cmd    = cmd[CMD_TRIGGER];
   assign c_init    = cmd[CMD_INITIATE];
   assign c_cstop   = cmd[CMD_CAL_STOP];
   assign c_cdef    = cmd[CMD_TRIM_FACTORY_DEFAULTS];
   assign c_restart = cmd[CMD_RESTART];
   assign c_stop    = cmd[CMD_STOP];
   assign id_ofs    = addr_reg - OFS_ID_BASE;
   assign pot_ofs   = addr_reg - OFS_POT_BASE;
   assign wr_id     = wr_pend_reg & (addr_reg >= OFS_ID_BASE)
                      & (id_ofs[11:2] < 10'(ID_CHARS));
   assign wr_pot_any = wr_pend_reg & (addr_reg >= OFS_POT_BASE)
                      & (pot_ofs[11:2] < 10'(NUM_POTS));

   // Calibration write attempt of any kind
   logic cal_attempt;
   assign cal_attempt = wr_pot_any | c_cdef
                      | (wr_pend_reg & ((addr_reg == OFS_VSCALE) | (addr_reg == OFS_CSCALE)
                                        | (addr_reg == OFS_INP_FS)));

   // ----------------------------------------------------------------
   // Protection latches and restart interlock
   // ----------------------------------------------------------------
   // Fault sets win over a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_reg <= '0;
      end else if (ce) begin
         latch_reg <= (latch_reg & ~{NUM_ALARMS{c_clear}}) | fault_in;
      end
   end

   // Run control: restart only with no fault and no latch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_reg    <= 1'b0;
         refuse_reg <= 1'b0;
      end else if (ce) begin
         if ((|fault_in) | (|latch_reg) | c_stop) begin
            run_reg <= 1'b0;
         end else if (c_restart) begin
            run_reg <= 1'b1;
         end
         if (c_restart & ((|fault_in) | (|latch_reg))) begin
            refuse_reg <= 1'b1;
         end else if (wr_pend_reg & (addr_reg == OFS_STATUS) & hwdata[STS_RST_REFUSE]) begin
            refuse_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Trigger system
   // ----------------------------------------------------------------
   logic cont;
   assign cont = cfg_reg[CFG_CONT];

   // Arm state: abort first, then trigger, then initiate
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trg_reg <= TRG_IDLE;
      end else if (ce) begin
         case (trg_reg)
            TRG_IDLE: begin
               if (cont | (c_init & ~c_abort)) begin
                  trg_reg <= TRG_ARMED;
               end
            end
            TRG_ARMED: begin
               if ((c_abort | c_trigger_fire_cmd) & ~cont) begin
                  trg_reg <= TRG_IDLE;
               end
            end
            default: begin
               trg_reg <= TRG_IDLE;
            end
         endcase
      end
   end

   // Condition word blanked for one cycle after a serviced trigger or abort
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opc_clear_reg <= 1'b0;
      end else if (ce) begin
         opc_clear_reg <= ((trg_reg == TRG_ARMED) & c_trigger_fire_cmd) | c_abort;
      end
   end

   // Pending and immediate levels
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_v_reg <= WORD_ZERO;
         pend_c_reg <= WORD_ZERO;
         imm_v_reg  <= WORD_ZERO;
         imm_c_reg  <= WORD_ZERO;
      end else if (ce) begin
         if (c_abort) begin
            pend_v_reg <= imm_v_reg;
            pend_c_reg <= imm_c_reg;
         end else if (c_trigger_fire_cmd & (trg_reg == TRG_ARMED)) begin
            imm_v_reg <= pend_v_reg;
            imm_c_reg <= pend_c_reg;
         end else if (wr_pend_reg & (addr_reg == OFS_PEND_V)) begin
            pend_v_reg <= hwdata;
         end else if (wr_pend_reg & (addr_reg == OFS_PEND_C)) begin
            pend_c_reg <= hwdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration switches
   // ----------------------------------------------------------------
   // Booleans held as single bits so they read back as 0 or 1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= CFG_RESET;
      end else if (ce) begin
         if (wr_pend_reg & (addr_reg == OFS_CONFIG)) begin
            cfg_reg <= hwdata[3:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Calibration session
   // ----------------------------------------------------------------
   // Session open on password match, closed by stop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cal_open_reg   <= 1'b0;
         cal_reject_reg <= 1'b0;
      end else if (ce) begin
         if (c_cstop) begin
            cal_open_reg <= 1'b0;
         end else if (wr_pend_reg & (addr_reg == OFS_CAL_PASS) & (hwdata == CAL_PASSWORD)) begin
            cal_open_reg <= 1'b1;
         end
         if (cal_attempt & ~cal_open_reg) begin
            cal_reject_reg <= 1'b1;
         end else if (wr_pend_reg & (addr_reg == OFS_STATUS) & hwdata[STS_CAL_REJECT]) begin
            cal_reject_reg <= 1'b0;
         end
      end
   end

   // Scale factors, only inside a session
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vscale_reg <= WORD_ZERO;
         cscale_reg <= WORD_ZERO;
         inp_fs_reg <= WORD_ZERO;
      end else if (ce & cal_open_reg & wr_pend_reg) begin
         if (addr_reg == OFS_VSCALE) begin
            vscale_reg <= hwdata;
         end
         if (addr_reg == OFS_CSCALE) begin
            cscale_reg <= hwdata;
         end
         if (addr_reg == OFS_INP_FS) begin
            inp_fs_reg <= hwdata;
         end
      end
   end

   // One trim pot per entry; defaults override a same-cycle write
   genvar gp;
   generate
      for (gp = 0; gp < NUM_POTS; gp++) begin : g_pot
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pot_reg[gp] <= POT_DEFAULT;
            end else if (ce & cal_open_reg) begin
               if (c_cdef) begin
                  pot_reg[gp] <= POT_DEFAULT;
               end else if (wr_pot_any & (pot_ofs[11:2] == 10'(gp))) begin
                  pot_reg[gp] <= hwdata[POT_W-1:0];
               end
            end
         end
         assign trim_pot_setting[gp*POT_W +: POT_W] = pot_reg[gp];
      end
   endgenerate

   // Identification string, one character per word
   always_ff @(posedge hclk) begin
      if (ce & wr_id) begin
         id_mem[id_ofs[8:2]] <= hwdata[7:0];
      end
   end

   // ----------------------------------------------------------------
   // Read data and condition word
   // ----------------------------------------------------------------
   logic [31:0] opcond;
   always_comb begin
      opcond = WORD_ZERO;
      if (!opc_clear_reg) begin
         opcond[OPC_ARM]   = (trg_reg == TRG_ARMED);
         opcond[OPC_INT]   = cfg_reg[CFG_FRONT];
         opcond[OPC_EXT]   = cfg_reg[CFG_EXTERN];
         opcond[OPC_WAIT]  = (trg_reg == TRG_ARMED);
         opcond[OPC_PWR]   = run_reg;
         opcond[OPC_RSEN]  = cfg_reg[CFG_SENSE];
         opcond[OPC_ALARM] = |latch_reg;
      end
   end

   // Register read mux; unmapped reads return zero
   always_comb begin
      rdata_next = WORD_ZERO;
      case (addr_reg)
         OFS_CONFIG: rdata_next = {28'h0000000, cfg_reg};
         OFS_OPCOND: rdata_next = opcond;
         OFS_ALARM:  rdata_next = {25'h0, latch_reg};
         OFS_IMM_V:  rdata_next = imm_v_reg;
         OFS_IMM_C:  rdata_next = imm_c_reg;
         OFS_PEND_V: rdata_next = pend_v_reg;
         OFS_PEND_C: rdata_next = pend_c_reg;
         OFS_STATUS: rdata_next = {29'h0, refuse_reg, cal_reject_reg, cal_open_reg};
         OFS_VSCALE: rdata_next = vscale_reg;
         OFS_CSCALE: rdata_next = cscale_reg;
         OFS_INP_FS: rdata_next = inp_fs_reg;
         default: begin
            if ((addr_reg >= OFS_POT_BASE) & (pot_ofs[11:2] < 10'(NUM_POTS))) begin
               rdata_next = {24'h000000, pot_reg[pot_ofs[4:2]]};
            end else if ((addr_reg >= OFS_ID_BASE) & (id_ofs[11:2] < 10'(ID_CHARS))) begin
               rdata_next = {24'h000000, id_mem[id_ofs[8:2]]};
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_run                    <= 1'b0;
         alarm_state                   <= 1'b0;
         applied_voltage_level         <= WORD_ZERO;
         applied_current_level         <= WORD_ZERO;
         waiting_for_trigger_flag      <= 1'b0;
         sense_location_select         <= 1'b0;
         front_panel_control_enable    <= 1'b0;
         external_input_control_enable <= 1'b0;
      end else if (ce) begin
         output_run                    <= run_reg;
         alarm_state                   <= |latch_reg;
         applied_voltage_level         <= imm_v_reg;
         applied_current_level         <= imm_c_reg;
         waiting_for_trigger_flag      <= (trg_reg == TRG_ARMED);
         sense_location_select         <= cfg_reg[CFG_SENSE];
         front_panel_control_enable    <= cfg_reg[CFG_FRONT];
         external_input_control_enable <= cfg_reg[CFG_EXTERN];
      end
   end

endmodule

/* src/stpc_pkg.sv */
/*
 * Shared constants for the supply trigger and protection controller:
 * register byte offsets, field positions, reset values and state codes.
 * Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
 */
package stpc_pkg;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CMD      = 12'h000;
   localparam logic [11:0] OFS_CONFIG   = 12'h004;
   localparam logic [11:0] OFS_OPCOND   = 12'h008;
   localparam logic [11:0] OFS_ALARM    = 12'h00C;
   localparam logic [11:0] OFS_IMM_V    = 12'h010;
   localparam logic [11:0] OFS_IMM_C    = 12'h014;
   localparam logic [11:0] OFS_PEND_V   = 12'h018;
   localparam logic [11:0] OFS_PEND_C   = 12'h01C;
   localparam logic [11:0] OFS_CAL_PASS = 12'h020;
   localparam logic [11:0] OFS_STATUS   = 12'h024;
   localparam logic [11:0] OFS_VSCALE   = 12'h02C;
   localparam logic [11:0] OFS_CSCALE   = 12'h030;
   localparam logic [11:0] OFS_INP_FS   = 12'h034;
   localparam logic [11:0] OFS_POT_BASE = 12'h040;
   localparam logic [11:0] OFS_ID_BASE  = 12'h100;

   // ----------------------------------------------------------------
   // Command word bits (write-only pulses)
   // ----------------------------------------------------------------
   localparam int CMD_PROT_CLEAR = 0;
   localparam int CMD_ABORT      = 1;
   localparam int CMD_TRIGGER    = 2;
   localparam int CMD_INITIATE   = 3;
   localparam int CMD_RECALL_RST = 4;
   localparam int CMD_CAL_STOP   = 5;
   localparam int CMD_TRIM_FACTORY_DEFAULTS    = 6;
   localparam int CMD_RESTART    = 7;
   localparam int CMD_STOP       = 8;

   // ----------------------------------------------------------------
   // Configuration bits
   // ----------------------------------------------------------------
   localparam int CFG_CONT   = 0;
   localparam int CFG_SENSE  = 1;
   localparam int CFG_FRONT  = 2;
   localparam int CFG_EXTERN = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // ----------------------------------------------------------------
   // Operation condition word bits
   // ----------------------------------------------------------------
   localparam int OPC_ARM   = 0;
   localparam int OPC_INT   = 3;
   localparam int OPC_EXT   = 4;
   localparam int OPC_WAIT  = 5;
   localparam int OPC_PWR   = 7;
   localparam int OPC_RSEN  = 9;
   localparam int OPC_ALARM = 11;

   // ----------------------------------------------------------------
   // Status bits
   // ----------------------------------------------------------------
   localparam int STS_CAL_OPEN   = 0;
   localparam int STS_CAL_REJECT = 1;
   localparam int STS_RST_REFUSE = 2;

   // ----------------------------------------------------------------
   // Sizes and reset values
   // ----------------------------------------------------------------
   localparam int NUM_ALARMS = 7;
   localparam int NUM_POTS   = 5;
   localparam int ID_CHARS   = 100;
   localparam int POT_W      = 8;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Trigger states, one-hot
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TRG_IDLE  = 2'b01,
      TRG_ARMED = 2'b10
   } stpc_trg_t;

endpackage

/* tb/stpc_checker.sv */
/* Protocol and trigger checker for stpc_ctrl.
   Bound to the controller; sees its ports only. */
module stpc_checker
   import stpc_pkg::*;
(
   // Clock and reset
   input wire logic                  hclk,
   input wire logic                  hresetn,
   input wire logic                  ce,
   // Bus
   input wire logic                  hsel,
   input wire logic [11:0]           haddr,
   input wire logic [1:0]            htrans,
   input wire logic                  hwrite,
   input wire logic                  hready,
   input wire logic [31:0]           hwdata,
   input wire logic                  hreadyout,
   input wire logic                  hresp,
   // Supply side
   input wire logic [NUM_ALARMS-1:0] fault_in,
   input wire logic                  output_run,
   input wire logic                  alarm_state,
   input wire logic                  waiting_for_trigger_flag,
   input wire logic                  sense_location_select
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic        wr_q;
   logic [11:0] a_q;
   logic [3:0]  cfg_q;
   wire         cmdw = wr_q && hready && a_q == OFS_CMD;
   wire         cfgw = wr_q && hready && a_q == OFS_CONFIG;
   // Track write data phases and the configuration word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= 1'h0;
         a_q   <= 12'h000;
         cfg_q <= CFG_RESET;
      end else if (ce && hready) begin
         wr_q <= hsel && htrans[1] && hwrite;
         a_q  <= haddr;
         if (cfgw) begin
            cfg_q <= hwdata[3:0];
         end
      end
   end
   a_resp_okay: assert property (hresp == 1'h0) else $error("bad response");
   a_write_nowait: assert property (wr_q |-> hreadyout) else $error("write stalled");
   a_read_wait: assert property (hsel && htrans[1] && hready && ce && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_fault_alarm: assert property (fault_in != 7'h00 |=> ##1 alarm_state) else $error("no alarm");
   a_fault_stop: assert property (fault_in != 7'h00 |=> ##1 !output_run) else $error("still running");
   a_clear_alarm: assert property (cmdw && hwdata[CMD_PROT_CLEAR] && fault_in == 7'h00 ##1 fault_in == 7'h00
      |=> !alarm_state) else $error("alarm kept");
   a_cfg_follow: assert property (cfgw |=> ##[0:1] sense_location_select == cfg_q[CFG_SENSE])
      else $error("sense wrong");
   a_abort_idle: assert property (cmdw && hwdata[CMD_ABORT] && !cfg_q[CFG_CONT]
      |=> ##1 !waiting_for_trigger_flag) else $error("abort kept flag");
   a_trigger_fire_cmd_once: assert property (cmdw && hwdata[CMD_TRIGGER] && !hwdata[CMD_INITIATE] && !cfg_q[CFG_CONT]
      && waiting_for_trigger_flag |=> ##1 !waiting_for_trigger_flag) else $error("armed twice");
   a_cont_armed: assert property (cfg_q[CFG_CONT] [*3] |-> waiting_for_trigger_flag)
      else $error("not armed");
endmodule
bind stpc_ctrl stpc_checker stpc_checker_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
   .fault_in(fault_in), .output_run(output_run), .alarm_state(alarm_state),
   .waiting_for_trigger_flag(waiting_for_trigger_flag), .sense_location_select(sense_location_select));

/* tb/stpc_fault_src.sv */
/* Fault detector model feeding the controller's alarm inputs.
   Assumes the bench requests faults as levels. */
module stpc_fault_src
   import stpc_pkg::*;
(
   // Clock and request
   input wire logic                  hclk,
   input wire logic [NUM_ALARMS-1:0] fault_req,
   // Fault lines
   output logic     [NUM_ALARMS-1:0] fault_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // Synchronous fault levels
   always_ff @(posedge hclk) begin
      fault_in <= fault_req;
   end
endmodule

/* tb/tb.sv */
/* Self-checking bench for stpc_ctrl over AHB-Lite.
   Assumes one slave, so hready is its own hreadyout. */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import stpc_pkg::*;
   logic                  hclk, hresetn, hsel, hwrite, hreadyout, hresp, run, alm, wtf, sns, fpe, exe, ce;
   logic [11:0]           haddr;
   logic [1:0]            htrans;
   logic [31:0]           hwdata, hrdata, av, ac, q;
   logic [NUM_ALARMS-1:0] fault_req, fault_in;
   logic [39:0]           pots;
   int                    error_cnt = 0;
   int                    num_checks = 0;
   stpc_ctrl stpc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .output_run(run),
      .alarm_state(alm), .applied_voltage_level(av), .applied_current_level(ac),
      .waiting_for_trigger_flag(wtf), .sense_location_select(sns), .front_panel_control_enable(fpe),
      .external_input_control_enable(exe), .trim_pot_setting(pots));
   stpc_fault_src stpc_fault_src_i (.hclk(hclk), .fault_req(fault_req), .fault_in(fault_in));
   // Clock
   initial begin
      hclk = 1'h0;
      forever #5 hclk = ~hclk;
   end
   task wrap_up;
      if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Wait for hready high at a rising edge, bounded
   task wt;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'h1 && n < 20);
      if (hreadyout !== 1'h1) begin
         error_cnt++;
         wrap_up;
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= a;
      wt;
      htrans <= 2'h0;
      hwdata <= d;
      wt;
      q = hrdata;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      bus(1'h1, a, d);
   endtask
   task rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'h0, a, 32'h0);
      chk(q, e);
   endtask
   task cmd(input int b);
      wr(OFS_CMD, 32'h1 << b);
   endtask
   task t_cfg;
      wr(OFS_CONFIG, 32'hE);
      rc(OFS_CONFIG, 32'hE);
      rc(OFS_OPCOND, 32'h218);
      chk(32'({sns, fpe, exe}), 32'h7);
      wr(OFS_CONFIG, 32'h0);
      rc(OFS_CONFIG, 32'h0);
      chk(32'({sns, fpe, exe}), 32'h0);
   endtask
   task t_trigger_fire_cmd;
      wr(OFS_PEND_V, 32'h5);
      wr(OFS_PEND_C, 32'h6);
      cmd(CMD_TRIGGER);
      rc(OFS_IMM_V, 32'h0);
      cmd(CMD_INITIATE);
      rc(OFS_OPCOND, 32'h21);
      chk(32'(wtf), 32'h1);
      cmd(CMD_TRIGGER);
      rc(OFS_IMM_C, 32'h6);
      chk(av, 32'h5);
      chk(ac, 32'h6);
      rc(OFS_OPCOND, 32'h0);
      wr(OFS_PEND_V, 32'h7);
      cmd(CMD_TRIGGER);
      rc(OFS_IMM_V, 32'h5);
      cmd(CMD_ABORT);
      rc(OFS_PEND_V, 32'h5);
      wr(OFS_CONFIG, 32'h1);
      rc(OFS_OPCOND, 32'h21);
      cmd(CMD_ABORT);
      rc(OFS_OPCOND, 32'h21);
      wr(OFS_PEND_V, 32'h9);
      cmd(CMD_TRIGGER);
      rc(OFS_OPCOND, 32'h21);
      chk(av, 32'h9);
      wr(OFS_PEND_V, 32'h3);
      cmd(CMD_RECALL_RST);
      rc(OFS_PEND_V, 32'h9);
      wr(OFS_CONFIG, 32'h0);
      cmd(CMD_ABORT);
      rc(OFS_OPCOND, 32'h0);
      ce <= 1'h0;
      cmd(CMD_INITIATE);
      ce <= 1'h1;
      rc(OFS_OPCOND, 32'h0);
   endtask
   task t_alarm;
      for (int i = 0; i < NUM_ALARMS; i++) begin
         fault_req <= 7'(32'h1 << i);
         repeat (3) @(posedge hclk);
         fault_req <= 7'h0;
         cmd(CMD_RESTART);
         rc(OFS_ALARM, 32'h1 << i);
         rc(OFS_STATUS, 32'h4);
         wr(OFS_STATUS, 32'h4);
         cmd(CMD_PROT_CLEAR);
         rc(OFS_ALARM, 32'h0);
      end
      cmd(CMD_RESTART);
      rc(OFS_OPCOND, 32'h80);
      chk(32'(run), 32'h1);
      fault_req <= 7'h10;
      cmd(CMD_RESTART);
      rc(OFS_OPCOND, 32'h800);
      chk(32'({run, alm}), 32'h1);
      fault_req <= 7'h0;
      cmd(CMD_PROT_CLEAR);
      rc(OFS_STATUS, 32'h4);
      wr(OFS_STATUS, 32'h4);
      cmd(CMD_RESTART);
      rc(OFS_OPCOND, 32'h80);
      cmd(CMD_STOP);
      rc(OFS_OPCOND, 32'h0);
   endtask
   task t_cal;
      wr(OFS_POT_BASE, 32'h11);
      rc(OFS_POT_BASE, 32'h80);
      rc(OFS_STATUS, 32'h2);
      wr(OFS_STATUS, 32'h2);
      wr(OFS_CAL_PASS, 32'h4321);
      rc(OFS_STATUS, 32'h0);
      wr(OFS_CAL_PASS, 32'h1234);
      rc(OFS_STATUS, 32'h1);
      for (int k = 0; k < NUM_POTS; k++) begin
         wr(OFS_POT_BASE + 12'(4 * k), k == 4 ? 32'hFF : 32'h33 * k);
         rc(OFS_POT_BASE + 12'(4 * k), k == 4 ? 32'hFF : 32'h33 * k);
         chk(32'(pots[8*k +: 8]), k == 4 ? 32'hFF : 32'h33 * k);
      end
      wr(OFS_VSCALE, 32'h160);
      wr(OFS_CSCALE, 32'h900);
      wr(OFS_INP_FS, 32'h10);
      rc(OFS_CSCALE, 32'h900);
      rc(OFS_INP_FS, 32'h10);
      cmd(CMD_TRIM_FACTORY_DEFAULTS);
      rc(OFS_POT_BASE + 12'h10, 32'h80);
      chk(pots[31:0], 32'h80808080);
      cmd(CMD_CAL_STOP);
      rc(OFS_STATUS, 32'h0);
      wr(OFS_VSCALE, 32'h5);
      rc(OFS_VSCALE, 32'h160);
      wr(OFS_ID_BASE + 12'h18C, 32'h5A);
      rc(OFS_ID_BASE + 12'h18C, 32'h5A);
      rc(12'h0FC, 32'h0);
   endtask
   // Main sequence
   initial begin
      hresetn = 1'h0;
      ce = 1'h1;
      hsel = 1'h0;
      hwrite = 1'h0;
      haddr = 12'h0;
      htrans = 2'h0;
      hwdata = 32'h0;
      fault_req = 7'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'h1;
      t_cfg;
      t_trigger_fire_cmd;
      t_alarm;
      t_cal;
      wrap_up;
   end
endmodule
